// ===== core/cst_defs.vh
/*
  constants for the charge safety timer and temperature control core:
  apb offsets, field positions, reset values and timing counts.
  assumes inclusion by its bare name from the core source.
*/
`ifndef CST_DEFS_VH
`define CST_DEFS_VH

// register byte offsets
`define CST_OFS_CTRL 12'h000
`define CST_OFS_ZONE 12'h004
`define CST_OFS_COMP 12'h008
`define CST_OFS_TERMINATION_VOLTAGE 12'h00C
`define CST_OFS_TIMER 12'h010
`define CST_OFS_STATUS 12'h014
`define CST_OFS_TARGET 12'h018

// ctrl fields
`define CST_CTRL_TH_DIS 0
`define CST_CTRL_ZONE_DIS 1
`define CST_CTRL_TERM_EN 2
`define CST_CTRL_TMR_DIS 3
`define CST_CTRL_TMR_SUSP 4
`define CST_CTRL_RCH_SEL 5
`define CST_CTRL_CELLS_LSB 8
`define CST_CTRL_RST 32'h0000_0300

// zone fields
`define CST_ZONE_COOL_LSB 0
`define CST_ZONE_KEEP 2
`define CST_ZONE_VDROP_LSB 3
`define CST_ZONE_HOT_LSB 6
`define CST_ZONE_COLD 8
`define CST_ZONE_RST 32'h0000_0003

// compensation fields
`define CST_COMP_CLAMP_LSB 0
`define CST_COMP_RES_LSB 3
`define CST_COMP_RST 32'h0000_0000

// termination voltage in mv (low half), termination current in ma (high half)
`define CST_TERMINATION_VOLTAGE_RST 32'h0064_3138
`define CST_TIMER_RST 32'h0000_000F

// compensation steps and per-cell recharge drops
`define CST_RES_STEP_MOHM 20
`define CST_CLAMP_STEP_MV 60
`define CST_RCH_LO_MV 100
`define CST_RCH_HI_MV 150

// timing
`define CST_CLK_PERIOD_NS 10
`define CST_TICK_TIME_NS 1_000_000_000
`define CST_TICK_CYCLES (`CST_TICK_TIME_NS / `CST_CLK_PERIOD_NS)
`define CST_LOWBAT_TIME_MIN 120
`define CST_FAST_STEP_MIN 30
`define CST_LOWBAT_TICKS (`CST_LOWBAT_TIME_MIN * 60)
`define CST_FAST_STEP_TICKS (`CST_FAST_STEP_MIN * 60)

`endif

// ===== core/cst_core.v
/*
  charge qualification core: temperature zones, simple threshold mode,
  path compensation of the termination target, full/terminate decision,
  recharge re-entry and the two safety timers, behind an apb slave.
  assumes comparator levels from the thermistor front end arrive
  asynchronously, and battery/loop levels come from logic on this clock.
*/
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cst_defs.vh"

module cst_core #(
  parameter TICK_CYCLES = `CST_TICK_CYCLES,
  parameter LOWBAT_TICKS = `CST_LOWBAT_TICKS,
  parameter FAST_STEP_TICKS = `CST_FAST_STEP_TICKS
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // thermistor comparators {gt65,gt60,gt55,gt45,lt10,lt0,ltm10}
  input wire [6:0] i_th_cmp,
  // battery and loop status
  input wire i_chg_enable,
  input wire i_sm_reset,
  input wire i_vbat_low,
  input wire [15:0] i_vbat_mv,
  input wire [15:0] i_programmed_charge_current_ma,
  input wire i_reg_vin,
  input wire i_reg_iin,
  input wire i_reg_die,
  // charge control
  output reg [1:0] o_fast_current_scale,
  output reg [15:0] o_termination_voltage_target_mv,
  output reg o_supply_enable,
  output reg o_temp_suspend,
  output reg [5:0] o_state,
  output reg o_fault
);

  localparam ST_RESET = 6'b000001;
  localparam ST_LOWBAT = 6'b000010;
  localparam ST_FAST = 6'b000100;
  localparam ST_FULL = 6'b001000;
  localparam ST_TERM = 6'b010000;
  localparam ST_FAULT = 6'b100000;

  // step constants held at the width of the arithmetic that uses them
  localparam [7:0] RES_STEP = `CST_RES_STEP_MOHM;
  localparam [15:0] CLAMP_STEP = `CST_CLAMP_STEP_MV;
  localparam [15:0] RCH_LO = `CST_RCH_LO_MV;
  localparam [15:0] RCH_HI = `CST_RCH_HI_MV;

  reg [31:0] ctrl_q;
  reg [31:0] zone_q;
  reg [31:0] comp_q;
  reg [31:0] termination_voltage_q;
  reg [31:0] timer_q;
  reg [5:0] state_q;
  reg [5:0] state_d;

  // comparator synchroniser, three stages, change accepted when 2 and 3 agree
  reg [6:0] th_s1_q;
  reg [6:0] th_s2_q;
  reg [6:0] th_s3_q;
  reg [6:0] th_q;
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_sync
      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          th_s1_q[g] <= 1'b0;
          th_s2_q[g] <= 1'b0;
          th_s3_q[g] <= 1'b0;
          th_q[g] <= 1'b0;
        end else begin
          th_s1_q[g] <= i_th_cmp[g];
          th_s2_q[g] <= th_s1_q[g];
          th_s3_q[g] <= th_s2_q[g];
          if (th_s2_q[g] == th_s3_q[g]) begin
            th_q[g] <= th_s3_q[g];
          end
        end
      end
    end
  endgenerate

  wire lt_m10 = th_q[0];
  wire lt_0 = th_q[1];
  wire lt_10 = th_q[2];
  wire gt_45 = th_q[3];
  wire gt_55 = th_q[4];
  wire gt_60 = th_q[5];
  wire gt_65 = th_q[6];

  wire th_dis = ctrl_q[`CST_CTRL_TH_DIS];
  wire zone_dis = ctrl_q[`CST_CTRL_ZONE_DIS];
  wire term_en = ctrl_q[`CST_CTRL_TERM_EN];
  wire tmr_dis = ctrl_q[`CST_CTRL_TMR_DIS];
  wire tmr_susp = ctrl_q[`CST_CTRL_TMR_SUSP];
  wire rch_sel = ctrl_q[`CST_CTRL_RCH_SEL];
  wire [2:0] cells = ctrl_q[`CST_CTRL_CELLS_LSB +: 3];
  wire [1:0] cool_sel = zone_q[`CST_ZONE_COOL_LSB +: 2];
  wire keep = zone_q[`CST_ZONE_KEEP];
  wire [2:0] vdrop_sel = zone_q[`CST_ZONE_VDROP_LSB +: 3];
  wire [1:0] hot_sel = zone_q[`CST_ZONE_HOT_LSB +: 2];
  wire cold_sel = zone_q[`CST_ZONE_COLD];
  wire [2:0] clamp_sel = comp_q[`CST_COMP_CLAMP_LSB +: 3];
  wire [2:0] res_sel = comp_q[`CST_COMP_RES_LSB +: 3];
  wire [15:0] termination_voltage_mv = termination_voltage_q[15:0];
  wire [15:0] iterm_ma = termination_voltage_q[31:16];
  wire [4:0] fast_sel = timer_q[4:0];

  // zone decode; hysteresis belongs to the comparators, not here
  wire zone_on = !th_dis && !zone_dis;
  wire simple_on = !th_dis && zone_dis;
  wire z_cold = zone_on && lt_0;
  wire z_cool = zone_on && !lt_0 && lt_10;
  wire z_warm = zone_on && gt_45 && !gt_60;
  wire z_hot = zone_on && gt_60;
  reg s_hot;
  always @* begin
    case (hot_sel)
      2'b00: s_hot = gt_55;
      2'b01: s_hot = gt_60;
      2'b10: s_hot = gt_65;
      default: s_hot = 1'b0;
    endcase
  end
  wire s_cold = cold_sel ? lt_m10 : lt_0;
  wire s_out = simple_on && (s_hot || s_cold);
  wire warm_vdrop = z_warm && (vdrop_sel != 3'b000);
  wire warm_half = z_warm && (vdrop_sel == 3'b000) && !keep;
  wire cool_off = z_cool && (cool_sel == 2'b00);
  wire temp_susp = z_cold || z_hot || cool_off || s_out;
  wire cool_half = z_cool && (cool_sel == 2'b01 || cool_sel == 2'b10);
  wire fast_half_zone = cool_half || warm_vdrop || warm_half;
  wire loops = i_reg_vin || i_reg_iin || i_reg_die;

  reg [1:0] scale_d;
  always @* begin
    scale_d = 2'd3;
    if (temp_susp) begin
      scale_d = 2'd0;
    end else if (z_cool) begin
      scale_d = cool_sel;
    end else if (warm_half) begin
      scale_d = 2'd2;
    end
  end

  // warm voltage reduction, 200 mv to 750 mv
  reg [15:0] drop_mv;
  always @* begin
    case (vdrop_sel)
      3'd1: drop_mv = 16'd200;
      3'd2: drop_mv = 16'd300;
      3'd3: drop_mv = 16'd400;
      3'd4: drop_mv = 16'd500;
      3'd5: drop_mv = 16'd600;
      3'd6: drop_mv = 16'd700;
      3'd7: drop_mv = 16'd750;
      default: drop_mv = 16'd0;
    endcase
  end

  // path compensation; mismatched fields give zero rise, see handover
  wire [7:0] res_mohm = {5'd0, res_sel} * RES_STEP;
  wire [15:0] clamp_mv = {13'd0, clamp_sel} * CLAMP_STEP;
  wire [23:0] ir_uv = i_programmed_charge_current_ma * res_mohm;
  wire [23:0] ir_mv_w = ir_uv / 24'd1000;
  wire [15:0] ir_mv = ir_mv_w[15:0];
  wire [15:0] rise_mv = (ir_mv < clamp_mv) ? ir_mv : clamp_mv;
  wire [15:0] drop_use = warm_vdrop ? drop_mv : 16'd0;
  wire [15:0] target_mv = termination_voltage_mv + rise_mv - drop_use;
  wire [15:0] rch_cell = rch_sel ? RCH_HI : RCH_LO;
  wire [15:0] rch_mv = rch_cell * {13'd0, cells};
  wire [15:0] rch_level = target_mv - rch_mv;

  // prescaled one-second tick
  reg [31:0] pre_q;
  reg tick_q;
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (pre_q == TICK_CYCLES - 1) begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // safety timers: index 0 low battery, index 1 fast charge
  wire in_low = (state_q == ST_LOWBAT);
  wire in_fast = (state_q == ST_FAST);
  wire clr_all = tmr_dis || i_sm_reset || !i_chg_enable ||
                 (state_q == ST_RESET) || (state_q == ST_FULL) ||
                 (state_q == ST_TERM);
  wire stop = tmr_susp || temp_susp;
  wire [1:0] t_clr = {clr_all || in_low, clr_all || in_fast};
  wire [1:0] t_run = {in_fast && !stop, in_low && !stop};
  wire [1:0] t_half = {loops || fast_half_zone, loops};
  wire [31:0] fast_limit = FAST_STEP_TICKS * ({27'd0, fast_sel} + 32'd1);
  wire [63:0] t_limit = {fast_limit, LOWBAT_TICKS[31:0]};
  reg [31:0] t_cnt_q [0:1];
  reg [1:0] t_phase_q;
  wire [1:0] t_exp;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_tmr
      assign t_exp[g] = !tmr_dis && (t_cnt_q[g] >= t_limit[32*g +: 32]);
      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          t_cnt_q[g] <= 32'h0000_0000;
          t_phase_q[g] <= 1'b0;
        end else if (t_clr[g]) begin
          t_cnt_q[g] <= 32'h0000_0000;
          t_phase_q[g] <= 1'b0;
        end else if (tick_q && t_run[g] && !t_exp[g]) begin
          // stopped timers simply skip this branch and hold
          t_phase_q[g] <= !t_phase_q[g];
          if (!t_half[g] || t_phase_q[g]) begin
            t_cnt_q[g] <= t_cnt_q[g] + 32'h0000_0001;
          end
        end
      end
    end
  endgenerate

  // charge qualification machine
  wire term_ok = (i_vbat_mv >= target_mv) && (i_programmed_charge_current_ma < iterm_ma) && !loops;
  always @* begin
    state_d = state_q;
    if (!i_chg_enable || i_sm_reset) begin
      state_d = ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_d = i_vbat_low ? ST_LOWBAT : ST_FAST;
        end
        ST_LOWBAT: begin
          if (t_exp[0]) begin
            state_d = ST_FAULT;
          end else if (!i_vbat_low) begin
            state_d = ST_FAST;
          end
        end
        ST_FAST: begin
          if (t_exp[1]) begin
            state_d = ST_FAULT;
          end else if (i_vbat_low) begin
            state_d = ST_LOWBAT;
          end else if (term_ok && !temp_susp) begin
            state_d = term_en ? ST_TERM : ST_FULL;
          end
        end
        ST_FULL: begin
          state_d = ST_FULL;
        end
        ST_TERM: begin
          if (i_vbat_mv < rch_level) begin
            state_d = ST_FAST;
          end
        end
        ST_FAULT: begin
          if (tmr_dis) begin
            state_d = ST_RESET;
          end
        end
        default: begin
          state_d = ST_RESET;
        end
      endcase
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // registered outputs
  wire charging = in_low || in_fast || (state_q == ST_FULL);
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fast_current_scale <= 2'd0;
      o_termination_voltage_target_mv <= 16'h0000;
      o_supply_enable <= 1'b0;
      o_temp_suspend <= 1'b0;
      o_state <= ST_RESET;
      o_fault <= 1'b0;
    end else begin
      o_fast_current_scale <= scale_d;
      o_termination_voltage_target_mv <= target_mv;
      o_supply_enable <= charging && !temp_susp;
      o_temp_suspend <= temp_susp;
      o_state <= state_q;
      o_fault <= (state_q == ST_FAULT);
    end
  end

  // apb slave, one wait-free access phase
  wire setup = i_psel && !i_penable;
  wire wr = i_psel && i_penable && o_pready && i_pwrite;
  reg hit;
  reg [31:0] rd_d;
  always @* begin
    hit = 1'b1;
    rd_d = 32'h0000_0000;
    case (i_paddr)
      `CST_OFS_CTRL: rd_d = ctrl_q;
      `CST_OFS_ZONE: rd_d = zone_q;
      `CST_OFS_COMP: rd_d = comp_q;
      `CST_OFS_TERMINATION_VOLTAGE: rd_d = termination_voltage_q;
      `CST_OFS_TIMER: rd_d = timer_q;
      `CST_OFS_STATUS: rd_d = {16'h0000, loops, fast_half_zone, temp_susp,
                               s_out, z_hot, z_warm, z_cool, z_cold,
                               2'b00, state_q};
      `CST_OFS_TARGET: rd_d = {16'h0000, target_mv};
      default: hit = 1'b0;
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_d;
        o_pslverr <= !hit;
      end
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `CST_CTRL_RST;
      zone_q <= `CST_ZONE_RST;
      comp_q <= `CST_COMP_RST;
      termination_voltage_q <= `CST_TERMINATION_VOLTAGE_RST;
      timer_q <= `CST_TIMER_RST;
    end else if (wr) begin
      case (i_paddr)
        `CST_OFS_CTRL: ctrl_q <= {21'd0, i_pwdata[10:8], 2'b00, i_pwdata[5:0]};
        `CST_OFS_ZONE: zone_q <= {23'd0, i_pwdata[8:0]};
        `CST_OFS_COMP: comp_q <= {26'd0, i_pwdata[5:0]};
        `CST_OFS_TERMINATION_VOLTAGE: termination_voltage_q <= i_pwdata;
        `CST_OFS_TIMER: timer_q <= {27'd0, i_pwdata[4:0]};
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== testbench/cst_core_properties.sv
/*
  port checker for cst_core: bus answer timing, state encoding, reset entry,
  termination gating and temperature suspend.
  assumes it is bound to every cst_core instance and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cst_core_props (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // observed inputs
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic i_chg_enable,
  input wire logic i_sm_reset,
  input wire logic i_reg_vin,
  input wire logic i_reg_iin,
  input wire logic i_reg_die,
  // observed outputs
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [1:0] o_fast_current_scale,
  input wire logic o_supply_enable,
  input wire logic o_temp_suspend,
  input wire logic [5:0] o_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire loop_on = i_reg_vin | i_reg_iin | i_reg_die;
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  // three cycles of fast state under an active loop rule out full or terminate next
  sequence s_fast_loop;
    loop_on && o_state == 6'd4;
  endsequence
  property p_ready; s_setup |=> o_pready; endproperty
  a_ready: assert property (p_ready)
    else $error("pready missing after setup");
  property p_ready_cause; o_pready |-> $past(i_psel && !i_penable); endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without setup");
  property p_unmapped; s_setup ##0 (i_paddr > 12'h018) |=> o_pslverr; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("no error for unmapped address");
  property p_onehot; $onehot(o_state); endproperty
  a_onehot: assert property (p_onehot)
    else $error("state not one-hot");
  property p_sm_reset; i_sm_reset |-> ##[1:3] o_state == 6'd1; endproperty
  a_sm_reset: assert property (p_sm_reset)
    else $error("machine reset not entered");
  property p_leave; !i_chg_enable |-> ##[1:3] o_state == 6'd1; endproperty
  a_leave: assert property (p_leave)
    else $error("leaving charge mode kept state");
  property p_term_off; o_state == 6'd16 && $past(o_state) == 6'd16 |-> !o_supply_enable; endproperty
  a_term_off: assert property (p_term_off)
    else $error("current supplied while terminated");
  property p_loop_hold; s_fast_loop [*3] |=> !o_state[3] && !o_state[4]; endproperty
  a_loop_hold: assert property (p_loop_hold)
    else $error("fast charge left with loop active");
  property p_temp_susp; o_temp_suspend |-> o_fast_current_scale == 2'd0; endproperty
  a_temp_susp: assert property (p_temp_susp)
    else $error("current allowed during temperature suspend");
endmodule

bind cst_core cst_core_props u_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .i_chg_enable(i_chg_enable), .i_sm_reset(i_sm_reset),
  .i_reg_vin(i_reg_vin), .i_reg_iin(i_reg_iin), .i_reg_die(i_reg_die),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_fast_current_scale(o_fast_current_scale),
  .o_supply_enable(o_supply_enable), .o_temp_suspend(o_temp_suspend), .o_state(o_state)
);
`default_nettype wire

// ===== testbench/testbench.sv
/*
  self-checking bench for cst_core: apb tasks, zone table, timers, termination.
  assumes cst_defs.vh on the include path and the port checker bound.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cst_defs.vh"
module testbench;
  logic i_core_clk = 0;
  logic i_rst = 1;
  logic i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0;
  logic [6:0] i_th_cmp = 0;
  logic i_chg_enable = 0, i_sm_reset = 0, i_vbat_low = 0;
  logic i_reg_vin = 0, i_reg_iin = 0, i_reg_die = 0;
  logic [15:0] i_vbat_mv = 16'd12000, i_programmed_charge_current_ma = 16'd1000;
  wire logic [31:0] o_prdata;
  wire logic o_pready, o_pslverr, o_supply_enable, o_temp_suspend, o_fault;
  wire logic [1:0] o_fast_current_scale;
  wire logic [15:0] o_termination_voltage_target_mv;
  wire logic [5:0] o_state;
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] rv [5] = '{`CST_CTRL_RST, `CST_ZONE_RST, `CST_COMP_RST, `CST_TERMINATION_VOLTAGE_RST,
    `CST_TIMER_RST};
  int ct[4][3] = '{'{'h13, 2000, 12680}, '{'h13, 6000, 12780}, '{'h3F, 6000, 13020},
    '{'h21, 6000, 12660}};
  // ctrl, zone, comparators, scale, suspend, target
  int zt[18][6] = '{'{'h308, 1, 4, 1, 0, 12600}, '{'h308, 2, 4, 2, 0, 12600},
    '{'h308, 3, 4, 3, 0, 12600}, '{'h308, 'hB, 8, 3, 0, 12400}, '{'h308, 4, 8, 3, 0, 12600},
    '{'h308, 3, 8, 2, 0, 12600}, '{'h308, 3, 'h38, 0, 1, 12600}, '{'h308, 3, 6, 0, 1, 12600},
    '{'h308, 3, 0, 3, 0, 12600}, '{'h30A, 3, 'h18, 0, 1, 12600}, '{'h30A, 'h43, 'h18, 3, 0, 12600},
    '{'h30A, 'hC3, 'h78, 3, 0, 12600}, '{'h30A, 3, 6, 0, 1, 12600}, '{'h30A, 'h103, 6, 3, 0, 12600},
    '{'h30A, 'h103, 7, 0, 1, 12600}, '{'h309, 3, 'h38, 3, 0, 12600},
    '{'h308, 0, 4, 0, 1, 12600}, '{'h308, 'h3B, 8, 3, 0, 11850}};
  // timer sel, low battery, comparators, die loop, quiet wait, expiry wait
  int tt[8][6] = '{'{1, 1, 0, 0, 68, 24}, '{1, 1, 0, 1, 140, 40}, '{1, 1, 4, 0, 68, 24},
    '{1, 0, 0, 0, 30, 24}, '{1, 0, 4, 0, 68, 30}, '{1, 0, 0, 1, 68, 30}, '{0, 0, 0, 0, 14, 14},
    '{1, 0, 8, 0, 68, 30}};

  always #5 i_core_clk = ~i_core_clk;

  // short counts keep timer expiry within a few hundred cycles
  cst_core #(.TICK_CYCLES(4), .LOWBAT_TICKS(20), .FAST_STEP_TICKS(5)) i_cst_core (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_th_cmp(i_th_cmp),
    .i_chg_enable(i_chg_enable), .i_sm_reset(i_sm_reset), .i_vbat_low(i_vbat_low),
    .i_vbat_mv(i_vbat_mv), .i_programmed_charge_current_ma(i_programmed_charge_current_ma), .i_reg_vin(i_reg_vin),
    .i_reg_iin(i_reg_iin), .i_reg_die(i_reg_die),
    .o_fast_current_scale(o_fast_current_scale), .o_termination_voltage_target_mv(o_termination_voltage_target_mv),
    .o_supply_enable(o_supply_enable), .o_temp_suspend(o_temp_suspend),
    .o_state(o_state), .o_fault(o_fault));

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input logic [5:0] exp);
    tests_run++;
    if (o_state !== exp || o_fault !== (exp == 6'd32)) begin
      bad_count++;
      $display("ERROR %0t state %h expected %h", $time, o_state, exp);
    end
  endtask

  // one apb transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("ERROR %0t apb transfer got no pready", $time);
    end
  endtask

  // leaving charge mode clears timers and any fault before each case
  task automatic restart(input logic low);
    i_chg_enable <= 1'b0;
    i_vbat_low <= low;
    cyc(8);
    i_chg_enable <= 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    cyc(6);
    i_rst <= 1'b0;
    chk_st(6'd1);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0000_0000);
      chk(rd, rv[k]);
    end
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      i_programmed_charge_current_ma <= 16'(ct[k][1]);
      apb(1'b1, 12'h008, ct[k][0]);
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk(32'(rd[15:0]), ct[k][2]);
      chk(32'(o_termination_voltage_target_mv), ct[k][2]);
    end
    apb(1'b1, 12'h008, 32'h0000_0000);
    i_programmed_charge_current_ma <= 16'd1000;
    i_chg_enable <= 1'b1;
    for (int k = 0; k < 18; k++) begin
      apb(1'b1, 12'h000, zt[k][0]);
      apb(1'b1, 12'h004, zt[k][1]);
      i_th_cmp <= 7'(zt[k][2]);
      cyc(8);
      chk(32'(o_fast_current_scale), zt[k][3]);
      chk(32'(o_temp_suspend), zt[k][4]);
      chk(32'(o_termination_voltage_target_mv), zt[k][5]);
    end
    apb(1'b1, 12'h000, 32'h0000_0300);
    apb(1'b1, 12'h004, 32'h0000_0001);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h010, tt[k][0]);
      i_th_cmp <= 7'(tt[k][2]);
      i_reg_die <= tt[k][3][0];
      restart(tt[k][1][0]);
      cyc(tt[k][4]);
      chk_st(tt[k][1] ? 6'd2 : 6'd4);
      cyc(tt[k][5]);
      chk_st(6'd32);
    end
    i_reg_die <= 1'b0;
    i_th_cmp <= 7'h00;
    for (int m = 0; m < 2; m++) begin
      restart(1'b1);
      cyc(40);
      if (m == 0) apb(1'b1, 12'h000, 32'h0000_0310);
      else i_th_cmp <= 7'h38;
      cyc(200);
      chk_st(6'd2);
      if (m == 0) apb(1'b1, 12'h000, 32'h0000_0300);
      else i_th_cmp <= 7'h00;
      cyc(55);
      chk_st(6'd32);
    end
    restart(1'b1);
    cyc(40);
    apb(1'b1, 12'h000, 32'h0000_0308);
    cyc(100);
    apb(1'b1, 12'h000, 32'h0000_0300);
    cyc(60);
    chk_st(6'd2);
    i_sm_reset <= 1'b1;
    cyc(3);
    chk_st(6'd1);
    i_sm_reset <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_030C);
    i_reg_iin <= 1'b1;
    i_vbat_mv <= 16'd12600;
    i_programmed_charge_current_ma <= 16'd50;
    restart(1'b0);
    cyc(10);
    chk_st(6'd4);
    i_reg_iin <= 1'b0;
    i_reg_vin <= 1'b1;
    cyc(10);
    chk_st(6'd4);
    i_reg_vin <= 1'b0;
    cyc(5);
    chk_st(6'd16);
    chk(32'(o_supply_enable), 32'h0000_0000);
    i_vbat_mv <= 16'd12300;
    cyc(5);
    chk_st(6'd16);
    i_vbat_mv <= 16'd12299;
    cyc(5);
    chk_st(6'd4);
    apb(1'b1, 12'h000, 32'h0000_0308);
    i_vbat_mv <= 16'd12600;
    cyc(5);
    i_vbat_mv <= 16'd11000;
    cyc(5);
    chk_st(6'd8);
    chk(32'(o_supply_enable), 32'h0000_0001);
    test_done();
  end
endmodule
`default_nettype wire
